// >>> common/clock_gate_pkg.sv
`default_nettype none

package clock_gate_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int UNITS  = 12;

    localparam logic [ADDR_W-1:0] RUN_CLOCK_ENABLE_1_OFS        = 12'h100;
    localparam logic [ADDR_W-1:0] SLEEP_CLOCK_ENABLE_1_OFS      = 12'h110;
    localparam logic [ADDR_W-1:0] DEEP_SLEEP_CLOCK_ENABLE_1_OFS = 12'h124;
    localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS          = 12'h060;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS                = 12'h200;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS                  = 12'h204;

    // ------------------------------------------------------------------
    // Field layout of the three gating registers
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] ENABLE_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ENABLE_WR_MASK  = 32'h000F_5137;
    localparam int               AUTO_GATING_BIT = 0;

    // Register bit of each unit; unit index order:
    // async0, async1, async2, sync0, sync1, quad0,
    // two_wire0, two_wire1, gp_counter0..3
    localparam int UNIT_POS [UNITS] = '{0, 1, 2, 4, 5, 8,
                                        12, 14, 16, 17, 18, 19};

    // ------------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP_SLEEP
    } power_mode_t;

endpackage

`default_nettype wire

// >>> logic/deep_sleep_clock_gating_reg1.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - A set enable bit lets the matching unit receive its clock.
// - A clear enable bit stops the unit clock and holds it disabled.
// - Any access to a unit whose clock is gated off ends in a fault.
// - After reset the register reads zero and every unit is unclocked.
// - The register is a 32-bit word at offset 0x124.
// - With auto gating selected, deep-sleep mode uses these enables.
// - Bits 19 to 16 enable general-purpose counters three to zero.
// - Bits 14, 12, 8, 5, 4, 2, 1 enable the other listed units.
// - Bit 0 enables asynchronous serial unit zero like the others.
// - Bits 31 to 20 and unassigned bits are read-only and read zero.
module deep_sleep_clock_gating_reg1 (
    input  wire logic                                sys_clk,
    input  wire logic                                sys_rst,
    // Wishbone slave
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [clock_gate_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                          wb_sel_i,
    input  wire logic [clock_gate_pkg::DATA_W-1:0]   wb_dat_i,
    output logic      [clock_gate_pkg::DATA_W-1:0]   wb_dat_o,
    output logic                                     wb_ack_o,
    // Power mode from the power controller
    input  wire clock_gate_pkg::power_mode_t         power_mode,
    // Peripheral side
    input  wire logic [clock_gate_pkg::UNITS-1:0]    periph_sel,
    output logic      [clock_gate_pkg::UNITS-1:0]    unit_clk_en,
    output logic      [clock_gate_pkg::UNITS-1:0]    unit_disable,
    output logic                                     periph_fault,
    output logic                                     irq
);

    localparam int U = clock_gate_pkg::UNITS;
    localparam int W = clock_gate_pkg::DATA_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] run_en;
        logic [W-1:0] sleep_en;
        logic [W-1:0] deep_en;
        logic         auto_sel;
        logic [U-1:0] irq_status;
        logic [U-1:0] irq_mask;
        logic         ack;
        logic [W-1:0] rdata;
        logic [U-1:0] clk_en;
        logic [U-1:0] disable_q;
        logic         fault;
        logic         irq;
    } state_t;

    state_t st;
    state_t next_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Gather the scattered enable bits into one bit per unit
    function automatic logic [U-1:0] gather(input logic [W-1:0] r);
        logic [U-1:0] v;
        v = '0;
        for (int i = 0; i < U; i++) begin
            v[i] = r[clock_gate_pkg::UNIT_POS[i]];
        end
        return v;
    endfunction

    // Byte-lane merge of a write, restricted to writable bits
    function automatic logic [W-1:0] merge(input logic [W-1:0] old,
                                           input logic [W-1:0] data,
                                           input logic [3:0]   lanes,
                                           input logic [W-1:0] wmask);
        logic [W-1:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{lanes[b]}};
        end
        m = m & wmask;
        return (old & ~m) | (data & m);
    endfunction

    // ------------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------------
    logic          bus_req;
    logic          wr_now;
    logic [U-1:0]  src_en;
    logic [U-1:0]  gated_hit;
    logic [U-1:0]  clr_bits;
    logic [U-1:0]  next_status;

    always_comb begin
        next_st = st;

        bus_req = wb_cyc_i && wb_stb_i;
        // A write lands on the edge where the master sees ack high
        wr_now  = bus_req && wb_we_i && st.ack;

        next_st.ack = bus_req && !st.ack;

        // Read data is prepared one cycle ahead so it is valid with ack
        next_st.rdata = '0;
        if (bus_req && !st.ack && !wb_we_i) begin
            case (wb_adr_i)
                clock_gate_pkg::RUN_CLOCK_ENABLE_1_OFS: begin
                    next_st.rdata = st.run_en;
                end
                clock_gate_pkg::SLEEP_CLOCK_ENABLE_1_OFS: begin
                    next_st.rdata = st.sleep_en;
                end
                clock_gate_pkg::DEEP_SLEEP_CLOCK_ENABLE_1_OFS: begin
                    next_st.rdata = st.deep_en;
                end
                clock_gate_pkg::RUN_CLOCK_CONFIG_OFS: begin
                    next_st.rdata[clock_gate_pkg::AUTO_GATING_BIT] =
                        st.auto_sel;
                end
                clock_gate_pkg::IRQ_STATUS_OFS: begin
                    next_st.rdata[U-1:0] = st.irq_status;
                end
                clock_gate_pkg::IRQ_MASK_OFS: begin
                    next_st.rdata[U-1:0] = st.irq_mask;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end

        clr_bits = '0;
        if (wr_now) begin
            case (wb_adr_i)
                clock_gate_pkg::RUN_CLOCK_ENABLE_1_OFS: begin
                    next_st.run_en = merge(st.run_en, wb_dat_i, wb_sel_i,
                        clock_gate_pkg::ENABLE_WR_MASK);
                end
                clock_gate_pkg::SLEEP_CLOCK_ENABLE_1_OFS: begin
                    next_st.sleep_en = merge(st.sleep_en, wb_dat_i,
                        wb_sel_i, clock_gate_pkg::ENABLE_WR_MASK);
                end
                clock_gate_pkg::DEEP_SLEEP_CLOCK_ENABLE_1_OFS: begin
                    // Reserved bits never store, so they read zero
                    next_st.deep_en = merge(st.deep_en, wb_dat_i, wb_sel_i,
                        clock_gate_pkg::ENABLE_WR_MASK);
                end
                clock_gate_pkg::RUN_CLOCK_CONFIG_OFS: begin
                    if (wb_sel_i[0]) begin
                        next_st.auto_sel =
                            wb_dat_i[clock_gate_pkg::AUTO_GATING_BIT];
                    end
                end
                clock_gate_pkg::IRQ_STATUS_OFS: begin
                    clr_bits = wb_dat_i[U-1:0] & {{(U-8){wb_sel_i[1]}},
                                                  {8{wb_sel_i[0]}}};
                end
                clock_gate_pkg::IRQ_MASK_OFS: begin
                    if (wb_sel_i[0]) begin
                        next_st.irq_mask[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        next_st.irq_mask[U-1:8] = wb_dat_i[U-1:8];
                    end
                end
                default: begin
                    next_st.run_en = st.run_en;
                end
            endcase
        end

        // Enables in force for the present power mode
        case (power_mode)
            clock_gate_pkg::MODE_SLEEP: begin
                src_en = st.auto_sel ? gather(st.sleep_en)
                                     : gather(st.run_en);
            end
            clock_gate_pkg::MODE_DEEP_SLEEP: begin
                src_en = st.auto_sel ? gather(st.deep_en)
                                     : gather(st.run_en);
            end
            default: begin
                src_en = gather(st.run_en);
            end
        endcase

        // Enables come from a flop so the external gate cell never sees a
        // glitch; it latches them while its clock is low
        next_st.clk_en    = src_en;
        next_st.disable_q = ~src_en;

        // Access to an unclocked unit: fault instead of a transfer
        gated_hit     = periph_sel & ~st.clk_en;
        next_st.fault = |gated_hit;

        // New fault wins over a clear in the same cycle
        next_status        = (st.irq_status & ~clr_bits) | gated_hit;
        next_st.irq_status = next_status;
        next_st.irq        = |(next_status & next_st.irq_mask);

        if (sys_rst) begin
            next_st            = '0;
            next_st.run_en     = clock_gate_pkg::ENABLE_RESET;
            next_st.sleep_en   = clock_gate_pkg::ENABLE_RESET;
            next_st.deep_en    = clock_gate_pkg::ENABLE_RESET;
            next_st.disable_q  = '1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o     = st.rdata;
    assign wb_ack_o     = st.ack;
    assign unit_clk_en  = st.clk_en;
    assign unit_disable = st.disable_q;
    assign periph_fault = st.fault;
    assign irq          = st.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_gated_access;
        (periph_sel & ~unit_clk_en) != '0;
    endsequence

    sequence s_deep_full_write;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hF
        && wb_adr_i == clock_gate_pkg::DEEP_SLEEP_CLOCK_ENABLE_1_OFS;
    endsequence

    sequence s_deep_read;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == clock_gate_pkg::DEEP_SLEEP_CLOCK_ENABLE_1_OFS;
    endsequence

    property p_reset_zero;
        @(posedge sys_clk) disable iff (1'b0)
        $past(sys_rst) |-> st.deep_en == '0 && unit_clk_en == '0
                           && unit_disable == '1;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("enables not cleared by reset");

    property p_disable_tracks;
        unit_disable == ~unit_clk_en;
    endproperty
    a_disable_tracks: assert property (p_disable_tracks)
        else $error("unit disable does not mirror gated clock");

    property p_fault_on_gated;
        s_gated_access |=> periph_fault;
    endproperty
    a_fault_on_gated: assert property (p_fault_on_gated)
        else $error("access to gated unit did not fault");

    property p_no_fault_clocked;
        (periph_sel & ~unit_clk_en) == '0 |=> !periph_fault;
    endproperty
    a_no_fault_clocked: assert property (p_no_fault_clocked)
        else $error("fault raised for a clocked unit");

    property p_deep_write_read;
        s_deep_full_write |=>
            st.deep_en == ($past(wb_dat_i) & clock_gate_pkg::ENABLE_WR_MASK);
    endproperty
    a_deep_write_read: assert property (p_deep_write_read)
        else $error("deep sleep enable write not stored");

    property p_reserved_zero;
        s_deep_read |=> (wb_dat_o & ~clock_gate_pkg::ENABLE_WR_MASK) == '0
                        && wb_ack_o;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read non-zero");

    property p_deep_select;
        (power_mode == clock_gate_pkg::MODE_DEEP_SLEEP && st.auto_sel)
        |=> unit_clk_en == gather($past(st.deep_en));
    endproperty
    a_deep_select: assert property (p_deep_select)
        else $error("deep sleep enables not applied");

    property p_sleep_select;
        (power_mode == clock_gate_pkg::MODE_SLEEP && st.auto_sel)
        |=> unit_clk_en == gather($past(st.sleep_en));
    endproperty
    a_sleep_select: assert property (p_sleep_select)
        else $error("sleep enables not applied under auto gating");

    property p_async_serial0_gate_bit;
        (power_mode == clock_gate_pkg::MODE_DEEP_SLEEP && st.auto_sel
         && st.deep_en[0]) |=> unit_clk_en[0];
    endproperty
    a_async_serial0_gate_bit: assert property (p_async_serial0_gate_bit)
        else $error("bit 0 does not enable async serial unit zero");

    // The enable flop lags its sources by one cycle, so the cause of a
    // change seen now lies between the two previous samples
    property p_change_has_cause;
        !$stable(unit_clk_en) |->
            $past(st.run_en, 2) != $past(st.run_en)
            || $past(st.sleep_en, 2) != $past(st.sleep_en)
            || $past(st.deep_en, 2) != $past(st.deep_en)
            || $past(st.auto_sel, 2) != $past(st.auto_sel)
            || $past(power_mode, 2) != $past(power_mode);
    endproperty
    a_change_has_cause: assert property (p_change_has_cause)
        else $error("clock enable changed without a cause");

    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("bus ack not a single cycle after request");

    // Without auto gating, or in run mode, the run register governs
    property p_run_default;
        (!st.auto_sel || power_mode == clock_gate_pkg::MODE_RUN)
        |=> unit_clk_en == gather($past(st.run_en));
    endproperty
    a_run_default: assert property (p_run_default)
        else $error("run enables not applied");

    // A fault always leaves its status bit set, even against a clear
    property p_status_set;
        s_gated_access |=>
            (st.irq_status & $past(periph_sel & ~unit_clk_en))
            == $past(periph_sel & ~unit_clk_en);
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("gated access did not set its status bit");

    property p_irq_level;
        irq == |(st.irq_status & st.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt does not follow masked status");

endmodule

`default_nettype wire

// >>> tb/periph_access_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Gated units and the fabric in front of them
// ------------------------------------------------------------------
module periph_access_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        req,
    input  wire logic [3:0]  unit,
    output logic      [11:0] periph_sel
);
    // One access cycle per request; the select idles low in between
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !req) begin
            periph_sel <= 12'h000;
        end else begin
            periph_sel <= 12'h001 << unit;
        end
    end
endmodule

`default_nettype wire

// >>> tb/deep_sleep_clock_gating_reg1_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module deep_sleep_clock_gating_reg1_tb_top;
    logic                        sys_clk, sys_rst, req;
    logic                        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0]                 wb_adr_i, periph_sel, unit_clk_en;
    logic [11:0]                 unit_disable;
    logic [3:0]                  wb_sel_i, unit;
    logic [31:0]                 wb_dat_i, wb_dat_o, rd;
    logic                        periph_fault, irq;
    clock_gate_pkg::power_mode_t power_mode;
    int                          fails, comparisons, cycles;

    deep_sleep_clock_gating_reg1 u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .power_mode(power_mode), .periph_sel(periph_sel),
        .unit_clk_en(unit_clk_en), .unit_disable(unit_disable),
        .periph_fault(periph_fault), .irq(irq)
    );

    periph_access_model u_units (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .unit(unit),
        .periph_sel(periph_sel)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle; the slave sets the pace, no latency assumed
    task automatic wb(input logic we, input logic [11:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64) begin
            fails++;
            $display("[ERR] ack expected 1 seen none");
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000, 4'hF);
        chk("read data", exp, rd);
    endtask

    task automatic go_mode(input clock_gate_pkg::power_mode_t m);
        @(posedge sys_clk);
        power_mode <= m;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic en_chk(input logic [11:0] exp);
        chk("unit_clk_en", {20'h0, exp}, {20'h0, unit_clk_en});
        chk("unit_disable", {20'h0, ~exp}, {20'h0, unit_disable});
    endtask

    // Far side touches one unit for one cycle; fault is due the cycle after
    task automatic access(input int u, input logic f);
        @(posedge sys_clk);
        req  <= 1'b1;
        unit <= 4'(u);
        @(posedge sys_clk);
        req  <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("periph_fault", {31'h0, f}, {31'h0, periph_fault});
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, req} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, unit} = '0;
        power_mode = clock_gate_pkg::MODE_RUN;
        sys_rst = 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(12'h124, 32'h0000_0000);
        en_chk(12'h000);
        wr(12'h124, 32'hFFFF_FFFF);
        rd_chk(12'h124, 32'h000F_5137);
        wb(1'b1, 12'h124, 32'h0000_0000, 4'h1);
        rd_chk(12'h124, 32'h000F_5100);
        wr(12'h3F0, 32'hFFFF_FFFF);
        rd_chk(12'h3F0, 32'h0000_0000);
        rd_chk(12'h120, 32'h0000_0000);
        // Run register still zero and no auto gating: all units gated
        go_mode(clock_gate_pkg::MODE_DEEP_SLEEP);
        wr(12'h204, 32'h0000_0FFF);
        access(3, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(12'h200, 32'h0000_0008);
        wr(12'h200, 32'h0000_0008);
        go_mode(clock_gate_pkg::MODE_DEEP_SLEEP);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'h060, 32'h0000_0001);
        // Software enables one unit at a time; touching it passes, the next one faults
        for (int i = 0; i < 12; i++) begin
            wr(12'h124, 32'h1 << clock_gate_pkg::UNIT_POS[i]);
            go_mode(clock_gate_pkg::MODE_DEEP_SLEEP);
            en_chk(12'h001 << i);
            access(i, 1'b0);
            access((i + 1) % 12, 1'b1);
        end
        wr(12'h200, 32'h0000_0FFF);
        wr(12'h110, 32'h000F_0000);
        go_mode(clock_gate_pkg::MODE_SLEEP);
        en_chk(12'hF00);
        wr(12'h100, 32'h0000_0001);
        go_mode(clock_gate_pkg::MODE_RUN);
        en_chk(12'h001);
        wr(12'h060, 32'h0000_0000);
        go_mode(clock_gate_pkg::MODE_DEEP_SLEEP);
        en_chk(12'h001);
        // Sleep without auto gating falls back to the run register
        go_mode(clock_gate_pkg::MODE_SLEEP);
        en_chk(12'h001);
        chk("irq", 32'h0, {31'h0, irq});
        complete_run();
    end
endmodule

`default_nettype wire
